/* File: swc_consts.svh */
// Register offsets, field positions, reset values and timing values in ns
// Assumes a 25 MHz ref_clk and a 7-bit register address
`ifndef SWC_CONSTS_SVH
`define SWC_CONSTS_SVH
`define SWC_ADDR_PAYLOAD5 7'h2E
`define SWC_ADDR_PAYLOAD4 7'h2F
`define SWC_ADDR_PAYLOAD3 7'h30
`define SWC_ADDR_PAYLOAD2 7'h31
`define SWC_ADDR_PAYLOAD1 7'h32
`define SWC_ADDR_PAYLOAD0 7'h33
`define SWC_ADDR_FD_CFG 7'h34
`define SWC_ADDR_OSC_TRIM 7'h38
`define SWC_ADDR_OPT 7'h39
`define SWC_PAYLOAD_RESET 8'h00
`define SWC_FD_CFG_RESET 8'h00
`define SWC_FD_CFG_RW_MASK 8'h3F
`define SWC_FD_ERR_OFF_BIT 5
`define SWC_FD_SKIP_BIT 4
`define SWC_FD_TIME_MSB 3
`define SWC_FD_TIME_LSB 1
`define SWC_FD_ON_BIT 0
`define SWC_TRIM_MASK 8'h7F
`define SWC_TRIM_UNLOCK 2'h3
`define SWC_OPT_RX_BIT 7
`define SWC_CLK_PERIOD_NS 40
`define SWC_FILT_STEP_NS 50
`define SWC_FILT_LONG_NS 700
`endif

/* File: swc_pkg.sv */
// Types shared by the selective wake configuration block
// Assumes nothing outside itself
`default_nettype none
package swc_pkg;
   typedef enum logic [1:0] {SWC_IDLE, SWC_HIGH, SWC_PASS} swc_filt_state_t;
   typedef logic [7:0] swc_byte_t;
endpackage : swc_pkg
`default_nettype wire

/* File: swc_payload_mem.sv */
// Six-byte store for the expected wake frame payload
// Assumes one write port and registered read data on the same clock
`default_nettype none
`include "swc_consts.svh"
module swc_payload_mem (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic wr_en,
   input wire logic [2:0] wr_idx,
   input wire logic [7:0] wr_data,
   input wire logic [2:0] rd_idx,
   output logic [7:0] rd_data,
   output logic [47:0] all_bytes
);
   logic [7:0] mem_q [0:5];
   genvar gi;
   generate
      for (gi = 0; gi < 6; gi++)
      begin : g_byte
         // Restart is not srst, so contents survive it
         always_ff @(posedge ref_clk)
         begin
            if (srst)
               mem_q[gi] <= `SWC_PAYLOAD_RESET;
            else if (wr_en && wr_idx == 3'(gi))
               mem_q[gi] <= wr_data;
         end
         assign all_bytes[gi*8 +: 8] = mem_q[gi];
      end
   endgenerate
   always_ff @(posedge ref_clk)
   begin
      if (srst)
         rd_data <= 8'h00;
      else if (rd_idx < 3'h6)
         rd_data <= mem_q[rd_idx];
      else
         rd_data <= 8'h00;
   end
endmodule : swc_payload_mem
`default_nettype wire

/* File: swc_dom_filter.sv */
// Dominant pulse filter on the digital receive path
// Assumes rx_in is already synchronised; dominant is low
`default_nettype none
`include "swc_consts.svh"
module swc_dom_filter (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic [2:0] time_code,
   input wire logic rx_in,
   output logic rx_out
);
   localparam int STEP_CYC = (`SWC_FILT_STEP_NS + `SWC_CLK_PERIOD_NS - 1)
      / `SWC_CLK_PERIOD_NS;
   localparam int LONG_CYC = (`SWC_FILT_LONG_NS + `SWC_CLK_PERIOD_NS - 1)
      / `SWC_CLK_PERIOD_NS;
   logic [4:0] cnt_q;
   logic [4:0] need;
   swc_pkg::swc_filt_state_t st_q;
   // 50 ns steps round up at a 40 ns clock
   function automatic logic [4:0] code_cycles(input logic [2:0] c);
      int ns;
      ns = (int'(c) + 1) * `SWC_FILT_STEP_NS;
      if (c == 3'h7)
         return 5'(LONG_CYC);
      return 5'((ns + `SWC_CLK_PERIOD_NS - 1) / `SWC_CLK_PERIOD_NS);
   endfunction : code_cycles
   assign need = code_cycles(time_code);
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         st_q <= swc_pkg::SWC_IDLE;
         cnt_q <= 5'h00;
         rx_out <= 1'b1;
      end
      else
      begin
         case (st_q)
            swc_pkg::SWC_IDLE:
            begin
               rx_out <= 1'b1;
               cnt_q <= 5'h01;
               if (!rx_in)
                  st_q <= swc_pkg::SWC_HIGH;
            end
            swc_pkg::SWC_HIGH:
            begin
               if (rx_in)
                  st_q <= swc_pkg::SWC_IDLE;
               else if (cnt_q >= need)
               begin
                  rx_out <= 1'b0;
                  st_q <= swc_pkg::SWC_PASS;
               end
               else
                  cnt_q <= cnt_q + 5'h01;
            end
            swc_pkg::SWC_PASS:
            begin
               if (rx_in)
               begin
                  rx_out <= 1'b1;
                  st_q <= swc_pkg::SWC_IDLE;
               end
            end
            default:
               st_q <= swc_pkg::SWC_IDLE;
         endcase
      end
   end
   // STEP_CYC kept as the shortest legal pulse reference
   logic unused_step;
   assign unused_step = (STEP_CYC == 0);
endmodule : swc_dom_filter
`default_nettype wire

/* File: swc_wake_cfg.sv */
// Selective wake frame configuration registers and receive path select
// Assumes a simple same-clock register port and an async bus receive pin
`default_nettype none
`include "swc_consts.svh"
module swc_wake_cfg (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic restart,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [6:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_hit,
   input wire logic [1:0] trim_unlock,
   input wire logic [7:0] trim_preset,
   input wire logic trim_preset_load,
   input wire logic silence_expired,
   input wire logic rx_raw,
   input wire logic rx_analog_filtered,
   output logic rx_filtered,
   output logic [47:0] payload_bytes,
   output logic tolerant_on,
   output logic error_counter_off,
   output logic receive_filter_skip,
   output logic [2:0] dominant_pulse_filter_time,
   output logic standard_receiver_sel,
   output logic [6:0] osc_trim
);
   logic [7:0] fd_cfg_q;
   logic [7:0] fd_cfg_d;
   logic [7:0] trim_q;
   logic opt_rx_q;
   logic rx_meta_q;
   logic rx_sync_q;
   logic rxf_meta_q;
   logic rxf_sync_q;
   logic [7:0] mem_rdata;
   logic [7:0] rd_mux_q;
   logic rd_from_mem_q;
   logic [2:0] last_idx_q;
   logic [2:0] rd_idx_sel;
   logic [2:0] mem_idx;
   logic is_payload;
   logic wr_fd;
   logic wr_trim;
   logic wr_opt;
   logic pre_filter;

   // Payload addresses map linearly: byte5 lowest address
   function automatic logic [2:0] payload_index(input logic [6:0] a);
      return 3'(7'(`SWC_ADDR_PAYLOAD0) - a);
   endfunction : payload_index

   assign is_payload = (reg_addr >= `SWC_ADDR_PAYLOAD5)
      && (reg_addr <= `SWC_ADDR_PAYLOAD0);
   assign mem_idx = payload_index(reg_addr);
   assign wr_fd = reg_wr && reg_addr == `SWC_ADDR_FD_CFG;
   assign wr_trim = reg_wr && reg_addr == `SWC_ADDR_OSC_TRIM;
   assign wr_opt = reg_wr && reg_addr == `SWC_ADDR_OPT
      && trim_unlock == `SWC_TRIM_UNLOCK;
   // Hold the last read index so read data follows that byte, writes included, until the next read
   assign rd_idx_sel = (reg_rd && is_payload) ? mem_idx : last_idx_q;
   assign reg_hit = is_payload || reg_addr == `SWC_ADDR_FD_CFG
      || reg_addr == `SWC_ADDR_OSC_TRIM || reg_addr == `SWC_ADDR_OPT;

   swc_payload_mem u_payload (
      .ref_clk(ref_clk),
      .srst(srst),
      .wr_en(reg_wr && is_payload),
      .wr_idx(mem_idx),
      .wr_data(reg_wdata),
      .rd_idx(rd_idx_sel),
      .rd_data(mem_rdata),
      .all_bytes(payload_bytes)
   );

   // Hardware clear beats a same-cycle software write
   always_comb
   begin
      fd_cfg_d = fd_cfg_q;
      if (wr_fd)
         fd_cfg_d = reg_wdata & `SWC_FD_CFG_RW_MASK;
      if (silence_expired)
         fd_cfg_d[`SWC_FD_ERR_OFF_BIT] = 1'b0;
      if (restart)
         fd_cfg_d[7:6] = 2'h0;
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
         fd_cfg_q <= `SWC_FD_CFG_RESET;
      else
         fd_cfg_q <= fd_cfg_d;
   end

   // Trim has no reset; factory preset loads it
   always_ff @(posedge ref_clk)
   begin
      if (trim_preset_load)
         trim_q <= trim_preset;
      else if (wr_trim && trim_unlock == `SWC_TRIM_UNLOCK)
         trim_q <= {trim_q[7], reg_wdata[6:0]};
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
         opt_rx_q <= 1'b0;
      else if (wr_opt)
         opt_rx_q <= reg_wdata[`SWC_OPT_RX_BIT];
   end

   assign tolerant_on = fd_cfg_q[`SWC_FD_ON_BIT];
   assign error_counter_off = fd_cfg_q[`SWC_FD_ERR_OFF_BIT]
      && fd_cfg_q[`SWC_FD_ON_BIT];
   assign receive_filter_skip = fd_cfg_q[`SWC_FD_SKIP_BIT];
   assign dominant_pulse_filter_time =
      fd_cfg_q[`SWC_FD_TIME_MSB:`SWC_FD_TIME_LSB];
   assign standard_receiver_sel = opt_rx_q;
   assign osc_trim = trim_q[6:0] & 7'(`SWC_TRIM_MASK);

   // Both receive inputs come from pins
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         rx_meta_q <= 1'b1;
         rx_sync_q <= 1'b1;
         rxf_meta_q <= 1'b1;
         rxf_sync_q <= 1'b1;
      end
      else
      begin
         rx_meta_q <= rx_raw;
         rx_sync_q <= rx_meta_q;
         rxf_meta_q <= rx_analog_filtered;
         rxf_sync_q <= rxf_meta_q;
      end
   end

   assign pre_filter = receive_filter_skip ? rx_sync_q : rxf_sync_q;

   // Dominant filter sits after the skip mux
   swc_dom_filter u_dom (
      .ref_clk(ref_clk),
      .srst(srst),
      .time_code(dominant_pulse_filter_time),
      .rx_in(pre_filter),
      .rx_out(rx_filtered)
   );

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         rd_mux_q <= 8'h00;
         rd_from_mem_q <= 1'b0;
         last_idx_q <= 3'h7;
      end
      else if (reg_rd)
      begin
         rd_from_mem_q <= is_payload;
         last_idx_q <= is_payload ? mem_idx : 3'h7;
         case (reg_addr)
            `SWC_ADDR_FD_CFG:
               rd_mux_q <= fd_cfg_q & `SWC_FD_CFG_RW_MASK;
            `SWC_ADDR_OSC_TRIM:
               rd_mux_q <= trim_q;
            `SWC_ADDR_OPT:
               rd_mux_q <= {opt_rx_q, 7'h00};
            default:
               rd_mux_q <= 8'h00;
         endcase
      end
   end

   assign reg_rdata = rd_from_mem_q ? mem_rdata : rd_mux_q;
endmodule : swc_wake_cfg
`default_nettype wire

/* File: swc_wake_cfg_props.sv */
// Port checker for the wake configuration registers
// Assumes swc_consts.svh and the single ref_clk domain
`default_nettype none
`include "swc_consts.svh"
module swc_wake_cfg_props (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic restart,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [6:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic trim_preset_load,
   input wire logic [1:0] trim_unlock,
   input wire logic silence_expired,
   input wire logic [47:0] payload_bytes,
   input wire logic tolerant_on,
   input wire logic error_counter_off,
   input wire logic receive_filter_skip,
   input wire logic [2:0] dominant_pulse_filter_time,
   input wire logic [6:0] osc_trim
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);
   sequence trim_wr;
      reg_wr && reg_addr == `SWC_ADDR_OSC_TRIM && !trim_preset_load;
   endsequence
   sequence fd_rd;
      reg_rd && reg_addr == `SWC_ADDR_FD_CFG;
   endsequence
   chk_reset_clear: assert property (
      $fell(srst) |-> payload_bytes == 48'h0 && !tolerant_on
         && dominant_pulse_filter_time == 3'h0)
      else $error("reset left a value set");
   chk_restart_keep: assert property (
      restart && !reg_wr |=> $stable(payload_bytes))
      else $error("restart changed payload");
   chk_err_gate: assert property (
      error_counter_off |-> tolerant_on)
      else $error("counter off without tolerant mode");
   chk_silence_clear: assert property (
      silence_expired |=> !error_counter_off)
      else $error("silence did not clear counter off");
   chk_fd_readback: assert property (
      fd_rd |=> reg_rdata[4:0] == $past({receive_filter_skip,
         dominant_pulse_filter_time, tolerant_on}))
      else $error("config readback differs from outputs");
   chk_fd_reserved: assert property (
      fd_rd |=> reg_rdata[7:6] == 2'h0)
      else $error("reserved config bits not zero");
   chk_trim_lock: assert property (
      trim_wr ##0 trim_unlock != `SWC_TRIM_UNLOCK |=> $stable(osc_trim))
      else $error("locked trim changed");
   chk_trim_write: assert property (
      trim_wr ##0 trim_unlock == `SWC_TRIM_UNLOCK
         |=> osc_trim == $past(reg_wdata[6:0]))
      else $error("unlocked trim not written");
   chk_restart_trim: assert property (
      restart && !reg_wr && !trim_preset_load |=> $stable(osc_trim))
      else $error("restart changed trim");
   chk_payload_write: assert property (
      reg_wr && reg_addr == `SWC_ADDR_PAYLOAD5
         |=> payload_bytes[47:40] == $past(reg_wdata))
      else $error("payload byte not stored");
endmodule : swc_wake_cfg_props
bind swc_wake_cfg swc_wake_cfg_props u_swc_wake_cfg_props (.*);
`default_nettype wire

/* File: swc_can_node.sv */
// Bus node model sending dominant pulses to the receive pins
// Assumes dominant low; idle bus is recessive via termination
`default_nettype none
module swc_can_node #(
   parameter int ANALOG_MIN_NS = 400
) (
   output logic rx_raw,
   output logic rx_analog_filtered
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      rx_raw = 1'b1;
      rx_analog_filtered = 1'b1;
   end
   // Analog stage swallows pulses shorter than its limit
   task automatic send_dominant(input int len_ns);
      rx_raw = 1'b0;
      rx_analog_filtered = (len_ns < ANALOG_MIN_NS);
      #(len_ns);
      rx_raw = 1'b1;
      rx_analog_filtered = 1'b1;
   endtask : send_dominant
endmodule : swc_can_node
`default_nettype wire

/* File: tb_swc_wake_cfg.sv */
// Self-checking bench for the wake configuration registers
// Assumes swc_consts.svh, swc_pkg and the swc_can_node model
`default_nettype none
`include "swc_consts.svh"
module tb_swc_wake_cfg;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [6:0] a; logic [7:0] w; logic [1:0] u;
      swc_pkg::swc_byte_t e;} swc_row_t;
   logic ref_clk = 1'b0, srst = 1'b1, restart = 1'b0;
   logic reg_wr = 1'b0, reg_rd = 1'b0, trim_preset_load = 1'b0;
   logic [6:0] reg_addr = 7'h00;
   logic [7:0] reg_wdata = 8'h00, trim_preset = 8'h25, reg_rdata;
   logic [1:0] trim_unlock = 2'h0;
   logic silence_expired = 1'b0, seen, reg_hit, rx_raw, rx_filtered;
   logic rx_analog_filtered, tolerant_on, error_counter_off;
   logic receive_filter_skip, standard_receiver_sel;
   logic [2:0] dominant_pulse_filter_time;
   logic [47:0] payload_bytes;
   logic [6:0] osc_trim;
   int bad_count = 0, total_checks = 0;
   int need [8] = '{2, 3, 4, 5, 7, 8, 9, 18};
   swc_row_t rows [11] = '{'{7'h2E, 8'h81, 2'h0, 8'h81},
      '{7'h2F, 8'h42, 2'h0, 8'h42}, '{7'h30, 8'h24, 2'h0, 8'h24},
      '{7'h31, 8'h18, 2'h0, 8'h18}, '{7'h32, 8'hFF, 2'h0, 8'hFF},
      '{7'h33, 8'h01, 2'h0, 8'h01}, '{7'h34, 8'hFF, 2'h0, 8'h3F},
      '{7'h38, 8'h12, 2'h0, 8'h25}, '{7'h38, 8'h12, 2'h3, 8'h12},
      '{7'h38, 8'h7F, 2'h3, 8'h7F}, '{7'h7F, 8'hFF, 2'h3, 8'h00}};
   // Trim writes keep bit 7 at its preset value
   swc_wake_cfg u_swc_wake_cfg (.*);
   swc_can_node u_swc_can_node (.*);
   always #20 ref_clk = ~ref_clk;
   task automatic test_done;
      if (bad_count == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : test_done
   task automatic cmp(input logic [47:0] got, input logic [47:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   // Silence pulse rides with the write to test the clear race
   task automatic wr(input logic [6:0] a, input logic [7:0] d,
      input logic s);
      @(negedge ref_clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      silence_expired = s;
      @(negedge ref_clk);
      reg_wr = 1'b0;
      silence_expired = 1'b0;
   endtask : wr
   task automatic rdc(input logic [6:0] a, input logic [7:0] e);
      @(negedge ref_clk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge ref_clk);
      reg_rd = 1'b0;
      @(negedge ref_clk);
      cmp(reg_rdata, e);
   endtask : rdc
   // Odd 13 ns keeps the pulse edge off the clock edge
   task automatic pulse(input int cyc, input logic exp_low);
      seen = 1'b0;
      fork
         u_swc_can_node.send_dominant(cyc * 40 + 13);
         repeat (cyc + 10) @(posedge ref_clk) seen |= !rx_filtered;
      join
      cmp(seen, exp_low);
   endtask : pulse
   initial
   begin
      repeat (4) @(negedge ref_clk);
      srst = 1'b0;
      trim_preset_load = 1'b1;
      @(negedge ref_clk);
      trim_preset_load = 1'b0;
      rdc(`SWC_ADDR_OSC_TRIM, 8'h25);
      foreach (rows[i])
      begin
         trim_unlock = rows[i].u;
         wr(rows[i].a, rows[i].w, 1'b0);
         rdc(rows[i].a, rows[i].e);
      end
      cmp(payload_bytes, 48'h8142_2418_FF01);
      cmp(reg_hit, 1'b0);
      cmp(osc_trim, 7'h7F);
      cmp({error_counter_off, receive_filter_skip,
         dominant_pulse_filter_time, tolerant_on}, 48'h3F);
      wr(`SWC_ADDR_FD_CFG, 8'h3F, 1'b1);
      rdc(`SWC_ADDR_FD_CFG, 8'h1F);
      wr(`SWC_ADDR_FD_CFG, 8'h20, 1'b0);
      cmp(error_counter_off, 1'b0);
      @(negedge ref_clk);
      restart = 1'b1;
      @(negedge ref_clk);
      restart = 1'b0;
      cmp(payload_bytes, 48'h8142_2418_FF01);
      rdc(`SWC_ADDR_FD_CFG, 8'h20);
      trim_unlock = 2'h0;
      wr(`SWC_ADDR_OPT, 8'h80, 1'b0);
      cmp(standard_receiver_sel, 1'b0);
      trim_unlock = 2'h3;
      wr(`SWC_ADDR_OPT, 8'h80, 1'b0);
      cmp(reg_hit, 1'b1);
      cmp(standard_receiver_sel, 1'b1);
      wr(`SWC_ADDR_FD_CFG, 8'h00, 1'b0);
      pulse(5, 1'b0);
      for (int c = 0; c < 8; c++)
      begin
         wr(`SWC_ADDR_FD_CFG, 8'(16 + 2 * c), 1'b0);
         pulse(need[c] - 1, 1'b0);
         pulse(need[c] + 3, 1'b1);
      end
      @(negedge ref_clk);
      srst = 1'b1;
      @(negedge ref_clk);
      srst = 1'b0;
      cmp(payload_bytes, 48'h0);
      rdc(`SWC_ADDR_FD_CFG, 8'h00);
      rdc(`SWC_ADDR_OSC_TRIM, 8'h7F);
      test_done();
   end
   initial
   begin
      // Whole sequence needs about 400 cycles
      #(`SWC_CLK_PERIOD_NS * 5000);
      bad_count++;
      test_done();
   end
endmodule : tb_swc_wake_cfg
`default_nettype wire
